// file: design/vpic_map.svh
`ifndef VPIC_MAP_SVH
`define VPIC_MAP_SVH

// register byte offsets on the apb port
`define VPIC_SMR_BASE 12'h000
`define VPIC_SVR_BASE 12'h080
`define VPIC_IVR 12'h100
`define VPIC_FVR 12'h104
`define VPIC_ISR 12'h108
`define VPIC_IPR 12'h10C
`define VPIC_IMR 12'h110
`define VPIC_CISR 12'h114
`define VPIC_IECR 12'h120
`define VPIC_IDCR 12'h124
`define VPIC_ICCR 12'h128
`define VPIC_ISCR 12'h12C
`define VPIC_EOICR 12'h130
`define VPIC_SPU 12'h134

// source mode register fields
`define VPIC_PRIO_LSB 0
`define VPIC_PRIO_MSB 2
`define VPIC_TYPE_LSB 5
`define VPIC_TYPE_MSB 6

// core status register bits
`define VPIC_CISR_FAST 0
`define VPIC_CISR_NORMAL 1

// reset values
`define VPIC_REG_RST 32'h0000_0000
`define VPIC_ID_RST 5'h00

// priority stack depth, one entry per level
`define VPIC_STACK_DEPTH 8

`endif

// file: design/vpic_pkg.sv
package vpic_pkg;

   typedef logic [2:0] vpic_prio_t;
   typedef logic [4:0] vpic_id_t;

   // trigger type: bit 0 selects edge, bit 1 selects high / rising for external sources
   typedef enum logic [1:0] {
      VPIC_LOW_LEVEL = 2'h0,
      VPIC_FALL_EDGE = 2'h1,
      VPIC_HIGH_LEVEL = 2'h2,
      VPIC_RISE_EDGE = 2'h3
   } vpic_trig_t;

endpackage

// file: design/vpic_ctrl.sv
`timescale 1ns/1ps
`include "vpic_map.svh"


module vpic_ctrl #(
   parameter int NSRC = 32,
   parameter logic [31:0] EXT_MASK = 32'h3F00_0001
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [NSRC-1:0] i_src_irq,
   input wire logic i_protect_mode,
   output logic o_normal_request_line,
   output logic o_fast_request_line
);
   import vpic_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // active-high view of a source; internal sources are always active high
   function automatic logic src_active(input logic [1:0] trig, input logic ext,
                                       input logic lvl);
      logic pol;
      pol = ext ? trig[1] : 1'b1;
      return pol ? lvl : ~lvl;
   endfunction

   function automatic logic is_edge(input logic [31:0] mode);
      return mode[`VPIC_TYPE_LSB];
   endfunction

   function automatic vpic_prio_t prio_of(input logic [31:0] mode);
      return mode[`VPIC_PRIO_MSB:`VPIC_PRIO_LSB];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [31:0] src_mode [NSRC];
   logic [31:0] source_vector_slot [NSRC];
   logic [31:0] spurious_vector;
   logic [NSRC-1:0] source_mask_view;
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] sync1, sync2, sync3;
   logic [NSRC-1:0] act_now, act_prev, edge_evt, qual;
   logic ack_q, err_q;
   logic acc, rd, wr;
   logic hit_smr, hit_svr, hit_fixed;
   logic [4:0] idx;
   logic win_ok;
   vpic_id_t win_id;
   vpic_prio_t win_prio;
   logic irq_want, fast_want;
   logic spur_lock;
   logic cur_valid;
   vpic_id_t cur_id;
   vpic_prio_t cur_prio;
   logic [3:0] depth;
   vpic_id_t stk_id [`VPIC_STACK_DEPTH];
   vpic_prio_t stk_prio [`VPIC_STACK_DEPTH];
   logic mem_valid, mem_irq;
   vpic_id_t mem_id;
   vpic_prio_t mem_prio;
   logic rd_ivr, wr_ivr, rd_fvr, wr_eoi;
   logic do_take, do_spur, fast_ack;
   vpic_id_t take_id;
   vpic_prio_t take_prio;
   logic [NSRC-1:0] ack_mask;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, effects happen at the first access edge

   assign acc = i_psel & i_penable & ~ack_q;
   assign rd = acc & ~i_pwrite;
   assign wr = acc & i_pwrite;
   assign idx = i_paddr[6:2];
   assign hit_smr = (i_paddr[11:7] == 5'h00) && (i_paddr[1:0] == 2'h0);
   assign hit_svr = (i_paddr[11:7] == 5'h01) && (i_paddr[1:0] == 2'h0);

   always_comb begin
      case (i_paddr)
         `VPIC_IVR, `VPIC_FVR, `VPIC_ISR, `VPIC_IPR, `VPIC_IMR, `VPIC_CISR,
         `VPIC_IECR, `VPIC_IDCR, `VPIC_ICCR, `VPIC_ISCR, `VPIC_EOICR,
         `VPIC_SPU: hit_fixed = 1'b1;
         default: hit_fixed = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         ack_q <= acc;
         err_q <= acc & ~(hit_smr | hit_svr | hit_fixed);
      end
   end

   assign o_pready = ack_q;
   assign o_pslverr = err_q;

   ////////////////////////////////////////////////////////////////////////////
   // input synchroniser and edge detect

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= i_src_irq;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         act_now[i] = src_active(src_mode[i][`VPIC_TYPE_MSB:`VPIC_TYPE_LSB],
                                 EXT_MASK[i], sync2[i]);
         act_prev[i] = src_active(src_mode[i][`VPIC_TYPE_MSB:`VPIC_TYPE_LSB],
                                  EXT_MASK[i], sync3[i]);
         edge_evt[i] = act_now[i] & ~act_prev[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int i = 0; i < NSRC; i++) begin
            src_mode[i] <= `VPIC_REG_RST;
            source_vector_slot[i] <= `VPIC_REG_RST;
         end
         spurious_vector <= `VPIC_REG_RST;
      end else if (wr) begin
         if (hit_smr) begin
            // only priority and type bits are kept, the rest reads zero
            src_mode[idx] <= {25'h000_0000, i_pwdata[`VPIC_TYPE_MSB:`VPIC_TYPE_LSB],
                              2'h0, i_pwdata[`VPIC_PRIO_MSB:`VPIC_PRIO_LSB]};
         end
         if (hit_svr) begin
            source_vector_slot[idx] <= i_pwdata;
         end
         if (i_paddr == `VPIC_SPU) begin
            spurious_vector <= i_pwdata;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         source_mask_view <= '0;
      end else if (wr && i_paddr == `VPIC_IECR) begin
         source_mask_view <= source_mask_view | i_pwdata[NSRC-1:0];
      end else if (wr && i_paddr == `VPIC_IDCR) begin
         source_mask_view <= source_mask_view & ~i_pwdata[NSRC-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pending state; a new edge wins over a clear in the same cycle

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pend <= '0;
      end else begin
         for (int i = 0; i < NSRC; i++) begin
            if (is_edge(src_mode[i])) begin
               pend[i] <= edge_evt[i]
                  | (wr && i_paddr == `VPIC_ISCR && i_pwdata[i])
                  | (pend[i] & ~ack_mask[i]
                     & ~(wr && i_paddr == `VPIC_ICCR && i_pwdata[i]));
            end else begin
               pend[i] <= act_now[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // priority encoder

   assign qual = pend & source_mask_view;

   always_comb begin
      win_ok = 1'b0;
      win_id = `VPIC_ID_RST;
      win_prio = 3'h0;
      // descending scan with >= leaves the smallest number on a tie
      for (int i = NSRC - 1; i >= 1; i--) begin
         if (qual[i] && (!win_ok || prio_of(src_mode[i]) >= win_prio)) begin
            win_ok = 1'b1;
            win_id = 5'(i);
            win_prio = prio_of(src_mode[i]);
         end
      end
   end

   // only a level above the one in service may raise the line
   assign irq_want = win_ok && (!cur_valid || win_prio > cur_prio);
   assign fast_want = qual[0];

   assign o_normal_request_line = irq_want & ~spur_lock;
   assign o_fast_request_line = fast_want & ~spur_lock;

   ////////////////////////////////////////////////////////////////////////////
   // vector port actions

   assign rd_ivr = rd && i_paddr == `VPIC_IVR;
   assign wr_ivr = wr && i_paddr == `VPIC_IVR;
   assign rd_fvr = rd && i_paddr == `VPIC_FVR;
   assign wr_eoi = wr && i_paddr == `VPIC_EOICR;

   always_comb begin
      do_take = 1'b0;
      do_spur = 1'b0;
      take_id = win_id;
      take_prio = win_prio;
      if (i_protect_mode) begin
         // write commits what the read memorized
         if (wr_ivr && mem_valid) begin
            do_take = mem_irq;
            do_spur = ~mem_irq;
            take_id = mem_id;
            take_prio = mem_prio;
         end
      end else begin
         // normal mode: a write to the port does nothing here
         if (rd_ivr) begin
            do_take = irq_want;
            do_spur = ~irq_want;
         end
      end
      if (rd_fvr && !i_protect_mode && !fast_want) begin
         do_spur = 1'b1;
      end
   end

   assign fast_ack = rd_fvr & ~i_protect_mode & fast_want;

   always_comb begin
      ack_mask = '0;
      if (do_take && is_edge(src_mode[take_id])) begin
         ack_mask[take_id] = 1'b1;
      end
      if (fast_ack && is_edge(src_mode[0])) begin
         ack_mask[0] = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         spur_lock <= 1'b0;
      end else if (do_spur) begin
         spur_lock <= 1'b1;
      end else if (wr_eoi) begin
         spur_lock <= 1'b0;
      end
   end

   // protect mode memory of the last read
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mem_valid <= 1'b0;
         mem_irq <= 1'b0;
         mem_id <= `VPIC_ID_RST;
         mem_prio <= 3'h0;
      end else if (rd_ivr && i_protect_mode) begin
         mem_valid <= 1'b1;
         mem_irq <= irq_want;
         mem_id <= win_id;
         mem_prio <= win_prio;
      end else if (wr_ivr) begin
         mem_valid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // service context and level stack

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cur_valid <= 1'b0;
         cur_id <= `VPIC_ID_RST;
         cur_prio <= 3'h0;
         depth <= 4'h0;
         for (int i = 0; i < `VPIC_STACK_DEPTH; i++) begin
            stk_id[i] <= `VPIC_ID_RST;
            stk_prio[i] <= 3'h0;
         end
      end else if (do_take) begin
         // a take needs a strictly higher level, so eight entries never overflow
         if (cur_valid && depth < 4'(`VPIC_STACK_DEPTH)) begin
            stk_id[depth[2:0]] <= cur_id;
            stk_prio[depth[2:0]] <= cur_prio;
            depth <= depth + 4'h1;
         end
         cur_valid <= 1'b1;
         cur_id <= take_id;
         cur_prio <= take_prio;
      end else if (wr_eoi) begin
         if (depth != 4'h0) begin
            cur_id <= stk_id[3'(depth - 4'h1)];
            cur_prio <= stk_prio[3'(depth - 4'h1)];
            depth <= depth - 4'h1;
         end else begin
            cur_valid <= 1'b0;
            cur_id <= `VPIC_ID_RST;
            cur_prio <= 3'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, latched at the access edge

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_prdata <= `VPIC_REG_RST;
      end else if (rd) begin
         if (hit_smr) begin
            o_prdata <= src_mode[idx];
         end else if (hit_svr) begin
            o_prdata <= source_vector_slot[idx];
         end else begin
            case (i_paddr)
               `VPIC_IVR: o_prdata <= irq_want ? source_vector_slot[win_id]
                                               : spurious_vector;
               `VPIC_FVR: o_prdata <= fast_want ? source_vector_slot[0]
                                                : spurious_vector;
               `VPIC_ISR: o_prdata <= {27'h000_0000, cur_id};
               `VPIC_IPR: o_prdata <= 32'(pend);
               `VPIC_IMR: o_prdata <= 32'(source_mask_view);
               `VPIC_CISR: o_prdata <= {30'h0000_0000, o_normal_request_line,
                                        o_fast_request_line};
               `VPIC_SPU: o_prdata <= spurious_vector;
               default: o_prdata <= `VPIC_REG_RST;
            endcase
         end
      end
   end

endmodule

// file: tb/vpic_core_model.sv
`timescale 1ns/1ps

// core side: records which request lines were raised; service is run by the bench tasks
module vpic_core_model (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_normal_req,
   input wire logic i_fast_req,
   output logic o_normal_seen,
   output logic o_fast_seen
);
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_normal_seen <= 1'b0;
         o_fast_seen <= 1'b0;
      end else begin
         o_normal_seen <= o_normal_seen | i_normal_req;
         o_fast_seen <= o_fast_seen | i_fast_req;
      end
   end
endmodule

// file: tb/vpic_ctrl_props.sv
`timescale 1ns/1ps
`include "vpic_map.svh"

module vpic_ctrl_props #(
   parameter int NSRC = 32
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [NSRC-1:0] i_src_irq,
   input wire logic i_protect_mode,
   input wire logic o_normal_request_line,
   input wire logic o_fast_request_line
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic take;
   logic spur_lock;
   assign take = i_psel && i_penable && !o_pready;
   sequence s_ivr_rd;
      take && !i_pwrite && i_paddr == `VPIC_IVR;
   endsequence
   sequence s_ivr_wr;
      take && i_pwrite && i_paddr == `VPIC_IVR;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   // fast read outside protect mode with the fast line low locks both lines until end of service
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         spur_lock <= 1'b0;
      end else if (take && i_pwrite && i_paddr == `VPIC_EOICR) begin
         spur_lock <= 1'b0;
      end else if (take && !i_pwrite && i_paddr == `VPIC_FVR && !i_protect_mode
                   && !o_fast_request_line) begin
         spur_lock <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_ready_one_wait: assert property (take |=> o_pready)
      else $error("ready late");
   a_ready_single: assert property (o_pready |=> !o_pready)
      else $error("ready too long");
   a_err_with_ready: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");
   a_reserved_errs: assert property (take && !i_pwrite && i_paddr == 12'h118
      |=> o_pslverr && o_prdata == 32'h0000_0000)
      else $error("reserved read accepted");
   a_read_drops_req: assert property (s_ivr_rd ##0 !i_protect_mode
      |=> !o_normal_request_line)
      else $error("request kept after vector read");
   a_protect_rd_keeps: assert property (s_ivr_rd ##0 i_protect_mode
      ##0 o_normal_request_line |=> o_normal_request_line)
      else $error("protect read acknowledged");
   a_protect_wr_acks: assert property (s_ivr_wr ##0 i_protect_mode
      |=> !o_normal_request_line)
      else $error("protect write did not acknowledge");
   a_normal_wr_inert: assert property (s_ivr_wr ##0 !i_protect_mode
      |=> $stable(o_normal_request_line) && $stable(o_fast_request_line))
      else $error("normal vector write had effect");
   a_spurious_lock: assert property (spur_lock
      |-> !o_normal_request_line && !o_fast_request_line)
      else $error("request during spurious lock");
endmodule

bind vpic_ctrl vpic_ctrl_props #(.NSRC(NSRC)) i_props (.*);

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "vpic_map.svh"

module testbench;
   import vpic_pkg::*;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   localparam logic [31:0] VBASE = 32'h1000_0000;
   localparam logic [31:0] SPUV = 32'h5EED_0000;
   logic clk, rst, psel, penable, pwrite, pready, prot, nreq, freq, nseen, fseen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, src;
   int error_cnt, n_compared, cyc;

   vpic_ctrl i_dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(), .i_src_irq(src), .i_protect_mode(prot),
      .o_normal_request_line(nreq), .o_fast_request_line(freq));
   vpic_core_model i_core (.i_clk(clk), .i_sys_rst(rst), .i_normal_req(nreq),
      .i_fast_req(freq), .o_normal_seen(nseen), .o_fast_seen(fseen));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] vec(input int n);
      return VBASE + 32'(n);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one idle edge after release, so the next call never re-drives psel in the same step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // no local limit: only the bench timeout may end a hung transfer
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      apb(1'b0, a, ZERO, q);
      chk(q, exp);
   endtask
   task automatic wait_hi(input logic fast);
      int n;
      n = 0;
      while ((fast ? freq : nreq) !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk(32'(fast ? freq : nreq), 32'h0000_0001);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_setup;
      rd(`VPIC_IMR, ZERO);
      rd(`VPIC_ISR, ZERO);
      rd(12'h118, ZERO);
      for (int i = 0; i < 8; i++) begin
         wr(`VPIC_SVR_BASE + 12'(4 * i), vec(i));
      end
      wr(`VPIC_SPU, SPUV);
      wr(12'h00C, 32'h0000_0006);
      wr(12'h014, 32'h0000_0002);
      wr(12'h018, 32'h0000_0006);
      wr(12'h004, 32'h0000_0024);
      wr(`VPIC_IECR, 32'h0000_006B);
      rd(`VPIC_IMR, 32'h0000_006B);
      rd(12'h004, 32'h0000_0024);
   endtask
   task automatic t_nest;
      src[5] <= 1'b1;
      wait_hi(1'b0);
      rd(`VPIC_IVR, vec(5));
      rd(`VPIC_ISR, 32'h0000_0005);
      src[6:3] <= 4'h9;
      wait_hi(1'b0);
      rd(`VPIC_IVR, vec(3));
      src[3] <= 1'b0;
      wr(`VPIC_EOICR, ZERO);
      rd(`VPIC_ISR, 32'h0000_0005);
      rd(`VPIC_IVR, vec(6));
      src[6] <= 1'b0;
      wr(`VPIC_EOICR, ZERO);
      rd(`VPIC_ISR, 32'h0000_0005);
      wr(`VPIC_EOICR, ZERO);
      rd(`VPIC_ISR, ZERO);
      src[5] <= 1'b1;
      wait_hi(1'b0);
      src[3] <= 1'b1;
      repeat (6) @(posedge clk);
      rd(`VPIC_IVR, vec(3));
      src[5:3] <= 3'h0;
      repeat (6) @(posedge clk);
      wr(`VPIC_EOICR, ZERO);
      rd(`VPIC_ISR, ZERO);
   endtask
   task automatic t_edge;
      wr(`VPIC_ISCR, 32'h0000_0002);
      rd(`VPIC_IPR, 32'h0000_0002);
      wr(`VPIC_ICCR, 32'h0000_0002);
      rd(`VPIC_IPR, ZERO);
      wr(`VPIC_IDCR, 32'h0000_0002);
      wr(`VPIC_ISCR, 32'h0000_0002);
      rd(`VPIC_IMR, 32'h0000_0069);
      chk(32'(nreq), ZERO);
      wr(`VPIC_IECR, 32'h0000_0002);
      wait_hi(1'b0);
      rd(`VPIC_IVR, vec(1));
      rd(`VPIC_IPR, ZERO);
      wr(`VPIC_EOICR, ZERO);
   endtask
   task automatic t_fast;
      for (int t = 0; t < 4; t++) begin
         src[0] <= ~t[1];
         repeat (6) @(posedge clk);
         wr(`VPIC_SMR_BASE, {25'h000_0000, 2'(t), 5'h00});
         wr(`VPIC_ICCR, 32'h0000_0001);
         src[0] <= t[1];
         wait_hi(1'b1);
         chk(32'(nreq), ZERO);
         rd(`VPIC_CISR, 32'h0000_0001);
         rd(`VPIC_FVR, vec(0));
         src[0] <= ~t[1];
         repeat (6) @(posedge clk);
         wr(`VPIC_ICCR, 32'h0000_0001);
         chk(32'(freq), ZERO);
      end
   endtask
   task automatic t_spur_prot;
      rd(`VPIC_FVR, SPUV);
      rd(`VPIC_IVR, SPUV);
      // fast source is in rising-edge mode here, so its edge latches while locked
      src[5:0] <= 6'h21;
      repeat (8) @(posedge clk);
      chk(32'(nreq), ZERO);
      chk(32'(freq), ZERO);
      wr(`VPIC_EOICR, ZERO);
      wait_hi(1'b0);
      chk(32'(freq), 32'h0000_0001);
      wr(`VPIC_IVR, ZERO);
      rd(`VPIC_ISR, ZERO);
      prot <= 1'b1;
      rd(`VPIC_IVR, vec(5));
      rd(`VPIC_ISR, ZERO);
      chk(32'(nreq), 32'h0000_0001);
      wr(`VPIC_IVR, ZERO);
      rd(`VPIC_ISR, 32'h0000_0005);
      chk(32'(nreq), ZERO);
      prot <= 1'b0;
      src[5] <= 1'b0;
      repeat (6) @(posedge clk);
      wr(`VPIC_EOICR, ZERO);
      rd(`VPIC_ISR, ZERO);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // whole run is a few hundred cycles; the ceiling leaves ample margin
   initial begin
      cyc = 0;
      forever begin
         @(posedge clk);
         cyc++;
         if (cyc == 20000) begin
            error_cnt++;
            print_verdict;
         end
      end
   end
   initial begin
      error_cnt = 0;
      n_compared = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = ZERO;
      src = 32'h3F00_0001;
      prot = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_setup;
      t_nest;
      t_edge;
      t_fast;
      t_spur_prot;
      chk({30'h0000_0000, nseen, fseen}, 32'h0000_0003);
      print_verdict;
   end
endmodule
